// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "tbc_consts.vh"
module tb_top;
  reg clk;
  reg rst;
  reg [7:0] addr;
  reg [7:0] wdata;
  reg wr;
  reg rd;
  reg cnt_tick;
  reg [3:0] src_lvl;
  reg [3:0] src_en;
  wire [7:0] rdata;
  wire [3:0] ch_pin_in;
  wire [3:0] ch_pin_out;
  wire [3:0] ch_pin_oe_n;
  wire [3:0] ch_irq;
  wire ovf_irq;
  integer n_mismatch;
  integer check_count;
  integer k;
  integer p;
  reg [15:0] cnt;
  reg [15:0] modv;
  reg [7:0] rv;
  reg [7:0] vh;
  reg [1:0] els;
  reg [7:0] a_ctl [0:3];

  tbc_top i_tbc_top (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cnt_tick,
    .ch_pin_in, .ch_pin_out, .ch_pin_oe_n, .ch_irq, .ovf_irq);
  tbc_pin_model i_tbc_pin_model (.pin_out(ch_pin_out), .pin_oe_n(ch_pin_oe_n), .pin_in(ch_pin_in),
    .src_lvl(src_lvl), .src_en(src_en));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task wr_reg(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  end
  endtask

  task rd_reg(input [7:0] a);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    rv = rdata;
  end
  endtask

  task set_val(input integer ch, input [15:0] v);
  begin
    wr_reg(a_ctl[ch] + 8'h01, v[15:8]);
    wr_reg(a_ctl[ch] + 8'h02, v[7:0]);
  end
  endtask

  // Flags clear only after a read has seen them
  task clr_flag(input integer ch);
  begin
    rd_reg(a_ctl[ch]);
    wr_reg(a_ctl[ch], rv & 8'h7F);
  end
  endtask

  task tick(input integer n);
    integer i;
  begin
    for (i = 0; i < n; i = i + 1)
    begin
      @(posedge clk);
      cnt_tick <= 1'h1;
      @(posedge clk);
      cnt_tick <= 1'h0;
      cnt = (cnt == modv) ? 16'h0000 : cnt + 16'h0001;
    end
    @(posedge clk);
    #1;
  end
  endtask

  // Pin passes two sync stages; the edge is decoded from the second and sets the flag
  task pin_edge(input lvl);
  begin
    @(posedge clk);
    src_lvl[1] <= lvl;
    repeat (5) @(posedge clk);
    #1;
  end
  endtask

  task chk(input [15:0] got, input [15:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task results;
  begin
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    results;
  end

  initial
  begin
    rst = 1'h1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    cnt_tick = 1'h0;
    src_lvl = 4'h0;
    src_en = 4'hF;
    n_mismatch = 0;
    check_count = 0;
    cnt = 16'h0000;
    modv = 16'hFFFF;
    a_ctl[0] = `TBC_ADDR_CH0_CTRL;
    a_ctl[1] = `TBC_ADDR_CH1_CTRL;
    a_ctl[2] = `TBC_ADDR_CH2_CTRL;
    a_ctl[3] = `TBC_ADDR_CH3_CTRL;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd_reg(`TBC_ADDR_CH2_CTRL);
    chk(rv, `TBC_CTRL_RST);
    rd_reg(`TBC_ADDR_CH3_CTRL);
    chk(rv, `TBC_CTRL_RST);
    rd_reg(8'h50);
    chk(rv, 8'h00);
    wr_reg(`TBC_ADDR_CH3_CTRL, 8'h7F);
    wr_reg(`TBC_ADDR_CH2_CTRL, 8'h7F);
    rd_reg(`TBC_ADDR_CH2_CTRL);
    chk(rv, 8'h7F);
    rd_reg(`TBC_ADDR_CH3_CTRL);
    chk(rv, 8'h5F);
    chk(ch_pin_oe_n[3:2], 2'h2);
    wr_reg(`TBC_ADDR_CH2_CTRL, 8'h00);
    wr_reg(`TBC_ADDR_CH3_CTRL, 8'h00);
    wr_reg(`TBC_ADDR_MOD_LO, 8'h10);
    wr_reg(`TBC_ADDR_MOD_HI, 8'h00);
    modv = 16'h0010;
    wr_reg(`TBC_ADDR_TSC, 8'h40);
    for (k = 0; k < 4; k = k + 1)
    begin
      els = (k == 3) ? 2'h1 : 2'h3 - k[1:0];
      set_val(0, cnt + 16'h0003);
      wr_reg(a_ctl[0], {4'h5, els, 2'h0});
      tick(2);
      chk(ch_irq[0], 1'h0);
      tick(1);
      chk({ch_irq[0], ch_pin_out[0]}, {1'h1, ~k[0]});
      clr_flag(0);
    end
    set_val(0, cnt - 16'h0002);
    tick(5);
    chk({ch_irq[0], ovf_irq}, 2'h1);
    rd_reg(`TBC_ADDR_TSC);
    chk(rv, 8'hC0);
    wr_reg(`TBC_ADDR_TSC, 8'h00);
    chk(ovf_irq, 1'h0);
    rd_reg(`TBC_ADDR_TSC);
    chk(rv, 8'h00);
    set_val(0, 16'h000B);
    tick(11);
    chk(ch_irq[0], 1'h1);
    clr_flag(0);
    wr_reg(a_ctl[0], 8'h00);
    for (k = 1; k < 4; k = k + 1)
    begin
      wr_reg(a_ctl[1], {4'h4, k[1:0], 2'h0});
      tick(1);
      pin_edge(1'h1);
      chk(ch_irq[1], k[0]);
      if (k[0])
      begin
        rd_reg(a_ctl[1] + 8'h01);
        vh = rv;
        rd_reg(a_ctl[1] + 8'h02);
        chk({vh, rv}, cnt);
      end
      clr_flag(1);
      pin_edge(1'h0);
      chk(ch_irq[1], k[1]);
      clr_flag(1);
    end
    wr_reg(a_ctl[1], 8'h00);
    for (p = 0; p < 4; p = p + 2)
    begin
      tick(17 - cnt);
      wr_reg(a_ctl[p], 8'h68 | {p[1], 2'h0});
      set_val(p, 16'h0003);
      set_val(p + 1, 16'h0008);
      tick(3);
      chk({ch_irq[p], ch_pin_oe_n[p + 1], ch_pin_out[p]}, {2'h3, p[1]});
      clr_flag(p);
      tick(17);
      chk(ch_irq[p], 1'h0);
      tick(5);
      chk(ch_irq[p], 1'h1);
      clr_flag(p);
      wr_reg(a_ctl[p], 8'h00);
    end
    // Full duty parks the pin at overflow and blocks the compare action
    wr_reg(a_ctl[2], 8'h5F);
    tick(17 - cnt);
    chk(ch_pin_out[2], 1'h0);
    tick(3);
    chk({ch_irq[2], ch_pin_out[2]}, 2'h2);
    clr_flag(2);
    wr_reg(a_ctl[2], 8'h1A);
    tick(14);
    chk(ch_pin_out[2], 1'h1);
    tick(3);
    chk(ch_pin_out[2], 1'h0);
    results;
  end
endmodule

// ==== bench/tbc_asserts.sv ====
`timescale 1ns/1ps
`include "tbc_consts.vh"
module tbc_asserts (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // Counter and pins
  input wire cnt_tick,
  input wire [3:0] ch_pin_in,
  input wire [3:0] ch_pin_out,
  input wire [3:0] ch_pin_oe_n,
  // Requests
  input wire [3:0] ch_irq,
  input wire ovf_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  property p_rdata_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_ch3_no_b;
    rd && addr == `TBC_ADDR_CH3_CTRL |=> !rdata[5];
  endproperty
  a_ch3_no_b: assert property (p_ch3_no_b) else $error("channel 3 bit 5 not zero");

  // ----------------------------------------------------------------
  // Requests and pins
  // ----------------------------------------------------------------
  property p_irq_off;
    wr && addr == `TBC_ADDR_CH0_CTRL && !wdata[6] |=> !ch_irq[0];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("channel request while disabled");
  property p_ovf_off;
    wr && addr == `TBC_ADDR_TSC && !wdata[6] |=> !ovf_irq;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("overflow request while disabled");
  property p_pin1_free;
    wr && addr == `TBC_ADDR_CH0_CTRL && wdata[5] |=> ch_pin_oe_n[1];
  endproperty
  a_pin1_free: assert property (p_pin1_free) else $error("pin 1 driven while paired");
  property p_pin3_free;
    wr && addr == `TBC_ADDR_CH2_CTRL && wdata[5] |=> ch_pin_oe_n[3];
  endproperty
  a_pin3_free: assert property (p_pin3_free) else $error("pin 3 driven while paired");
  property p_cap_undriven;
    wr && addr == `TBC_ADDR_CH1_CTRL && wdata[5:4] == 2'h0 |=> ch_pin_oe_n[1];
  endproperty
  a_cap_undriven: assert property (p_cap_undriven) else $error("capture pin driven");
  // Mode writes may move the pin, so only counter-driven changes are judged
  property p_pin_on_tick;
    $changed(ch_pin_out[0]) && $stable(ch_pin_oe_n[0]) && !ch_pin_oe_n[0] && !$past(wr) && !$past(wr, 2)
      |-> $past(cnt_tick) || $past(cnt_tick, 2);
  endproperty
  a_pin_on_tick: assert property (p_pin_on_tick) else $error("pin moved without count");
  c_cmp: cover property ($rose(ch_irq[0]));
  c_cap: cover property ($rose(ch_irq[1]));
  c_ovf: cover property ($rose(ovf_irq));
endmodule

bind tbc_top tbc_asserts i_tbc_asserts (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cnt_tick,
  .ch_pin_in, .ch_pin_out, .ch_pin_oe_n, .ch_irq, .ovf_irq);

// ==== bench/tbc_pin_model.sv ====
`timescale 1ns/1ps
module tbc_pin_model (
  // Design side
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe_n,
  output wire [3:0] pin_in,
  // Event sources
  input wire [3:0] src_lvl,
  input wire [3:0] src_en
);
  // ----------------------------------------------------------------
  // Wire level
  // ----------------------------------------------------------------
  // A source acts as a load while the timer drives; an idle pin floats high
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & src_en & src_lvl) | (pin_oe_n & ~src_en);
endmodule

// ==== rtl/tbc_chan.v ====
`timescale 1ns/1ps
`include "tbc_consts.vh"
module tbc_chan (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Counter
  input wire cnt_upd,
  input wire ovf,
  input wire [15:0] cnt,
  input wire [15:0] cmp_val,
  // Mode
  input wire mode_a,
  input wire mode_b,
  input wire [1:0] els,
  input wire tov,
  input wire full,
  input wire off,
  // Pin
  input wire pin_s,
  output reg pin_o,
  output wire drive,
  // Events
  output wire cap,
  output wire evt
);

  reg pin_prev_q;
  wire rise;
  wire fall;
  wire cap_mode;
  wire cmp_mode;
  wire edge_hit;
  wire match;

  assign rise = pin_s & ~pin_prev_q;
  assign fall = ~pin_s & pin_prev_q;
  assign cap_mode = ~mode_a & ~mode_b & (els != `TBC_ELS_OFF) & ~off;
  assign cmp_mode = (mode_a | mode_b) & ~off;
  // RULE_02
  assign edge_hit = ((els == `TBC_ELS_RISE) & rise) | ((els == `TBC_ELS_FALL) & fall) |
                    ((els == `TBC_ELS_BOTH) & (rise | fall));
  assign cap = cap_mode & edge_hit; // RULE_01
  // Only an exact hit on a fresh count fires, so a value already passed waits a period
  assign match = cmp_mode & cnt_upd & (cnt == cmp_val); // RULE_07
  assign evt = cap | match;
  assign drive = cmp_mode & (els != `TBC_ELS_OFF);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_prev_q <= pin_s;
    end
  end

  // ----------------------------------------------------------------
  // Pin action
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_o <= 1'b0;
    end
    else if (drive)
    begin
      if (ovf & tov)
      begin
        // Full duty parks the pin at the pulse level so compares cannot end it
        if (full & (els == `TBC_ELS_CLEAR))
          pin_o <= 1'b1;
        else if (full & (els == `TBC_ELS_SET))
          pin_o <= 1'b0;
        else
          pin_o <= ~pin_o;
      end
      else if (match & ~full)
      begin
        case (els) // RULE_04
          `TBC_ELS_TOGGLE: pin_o <= ~pin_o;
          `TBC_ELS_CLEAR: pin_o <= 1'b0;
          `TBC_ELS_SET: pin_o <= 1'b1;
          default: pin_o <= pin_o;
        endcase
      end
    end
  end

endmodule

// ==== rtl/tbc_consts.vh ====
`ifndef TBC_CONSTS_VH
`define TBC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TBC_ADDR_TSC 8'h40
`define TBC_ADDR_CNT_HI 8'h41
`define TBC_ADDR_CNT_LO 8'h42
`define TBC_ADDR_MOD_HI 8'h43
`define TBC_ADDR_MOD_LO 8'h44
`define TBC_ADDR_CH0_CTRL 8'h45
`define TBC_ADDR_CH0_HI 8'h46
`define TBC_ADDR_CH0_LO 8'h47
`define TBC_ADDR_CH1_CTRL 8'h48
`define TBC_ADDR_CH1_HI 8'h49
`define TBC_ADDR_CH1_LO 8'h4A
`define TBC_ADDR_CH2_CTRL 8'h32
`define TBC_ADDR_CH2_HI 8'h33
`define TBC_ADDR_CH2_LO 8'h34
`define TBC_ADDR_CH3_CTRL 8'h35
`define TBC_ADDR_CH3_HI 8'h36
`define TBC_ADDR_CH3_LO 8'h37

// ----------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------
`define TBC_B_FLAG 7
`define TBC_B_IE 6
`define TBC_B_MSB 5
`define TBC_B_MSA 4
`define TBC_B_ELSB 3
`define TBC_B_ELSA 2
`define TBC_B_TOV 1
`define TBC_B_FULL 0
`define TBC_CTRL_WMASK 7'h7F
`define TBC_CH3_WMASK 7'h5F

// ----------------------------------------------------------------
// Timer status and control fields
// ----------------------------------------------------------------
`define TBC_B_TOF 7
`define TBC_B_TOIE 6
`define TBC_B_STOP 5
`define TBC_B_TRST 4
`define TBC_TSC_WMASK 7'h67

// ----------------------------------------------------------------
// Edge / level select codes
// ----------------------------------------------------------------
`define TBC_ELS_OFF 2'h0
`define TBC_ELS_RISE 2'h1
`define TBC_ELS_FALL 2'h2
`define TBC_ELS_BOTH 2'h3
`define TBC_ELS_TOGGLE 2'h1
`define TBC_ELS_CLEAR 2'h2
`define TBC_ELS_SET 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TBC_TSC_RST 8'h20
`define TBC_CTRL_RST 8'h00
`define TBC_CNT_RST 16'h0000
`define TBC_MOD_RST 16'hFFFF
`define TBC_VAL_RST 16'h0000

`endif

// ==== rtl/tbc_sync.v ====
`timescale 1ns/1ps
module tbc_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// ==== rtl/tbc_top.v ====
`timescale 1ns/1ps
`include "tbc_consts.vh"
// Function
// RULE_01: An active pin edge in capture mode copies the counter into the channel value.
// RULE_02: Software picks rising, falling or either edge per capture channel.
// RULE_03: A capture event requests an interrupt when the channel enable is set.
// RULE_04: On counter match a compare channel sets, clears or toggles its pin.
// RULE_05: A compare match requests an interrupt when the channel enable is set.
// RULE_06: Unbuffered compare uses the written value at once, no holding stage.
// RULE_07: Compare fires only on exact match; a passed value waits a period.
// RULE_08: Software lowers a value from the compare interrupt handler.
// RULE_09: Software raises a value from the overflow interrupt handler.
// RULE_10: Channel 0 buffer select links channels 0 and 1 onto pin 0.
// RULE_11: Pair 0/1 starts on channel 0, swaps to last written at overflow.
// RULE_12: While linked, channel 0 control runs the pair and pin 1 is released.
// RULE_13: Channel 2 buffer select links channels 2 and 3 onto pin 2.
// RULE_14: Pair 2/3 starts on channel 2, swaps to last written at overflow.
// RULE_15: While linked, channel 2 control runs the pair and pin 3 is released.
// RULE_16: Software writes only the inactive channel of a linked pair.
// RULE_17: Control layout: flag, irq enable, mode B, mode A, edge select, toggle, full.
// RULE_18: Channel 3 has no mode B bit; it reads as zero.
// RULE_19: A 16-bit counter, free or modulo, times all channels.
// RULE_20: Events set the flag; read then write zero clears it.
// RULE_21: Overflow occurs when the counter wraps from modulo to zero.
module tbc_top (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // Counter clock enable
  input wire cnt_tick,
  // Channel pins
  input wire [3:0] ch_pin_in,
  output wire [3:0] ch_pin_out,
  output wire [3:0] ch_pin_oe_n,
  // Interrupt requests
  output wire [3:0] ch_irq,
  output wire ovf_irq
);

  localparam [31:0] CTRL_ADDRS = {`TBC_ADDR_CH3_CTRL, `TBC_ADDR_CH2_CTRL, `TBC_ADDR_CH1_CTRL, `TBC_ADDR_CH0_CTRL};
  localparam [31:0] HI_ADDRS = {`TBC_ADDR_CH3_HI, `TBC_ADDR_CH2_HI, `TBC_ADDR_CH1_HI, `TBC_ADDR_CH0_HI};
  localparam [31:0] LO_ADDRS = {`TBC_ADDR_CH3_LO, `TBC_ADDR_CH2_LO, `TBC_ADDR_CH1_LO, `TBC_ADDR_CH0_LO};

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] tsc_q;
  reg tof_armed_q;
  reg [15:0] cnt_q;
  reg [15:0] mod_q;
  reg cnt_upd_q;
  reg [7:0] ctrl_q [0:3];
  reg [15:0] val_q [0:3];
  reg [3:0] armed_q;
  reg [1:0] link_q;
  reg [1:0] sel_q;
  reg [1:0] last_q;

  wire [3:0] hc;
  wire [3:0] hh;
  wire [3:0] hl;
  wire [3:0] pin_s;
  wire [3:0] evt;
  wire [3:0] cap;
  wire [3:0] drive;
  wire [1:0] link;
  wire ovf;
  wire counting;
  wire hit_tsc;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  tbc_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(ch_pin_in),
    .q(pin_s)
  );

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign hit_tsc = (addr == `TBC_ADDR_TSC);
  assign counting = cnt_tick & ~tsc_q[`TBC_B_STOP];
  assign ovf = counting & (cnt_q == mod_q); // RULE_21

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= `TBC_CNT_RST;
      cnt_upd_q <= 1'b0;
    end
    else
    begin
      cnt_upd_q <= counting;
      if (wr & hit_tsc & wdata[`TBC_B_TRST])
        cnt_q <= `TBC_CNT_RST;
      else if (ovf)
        cnt_q <= `TBC_CNT_RST;
      else if (counting)
        cnt_q <= cnt_q + 16'h0001; // RULE_19
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mod_q <= `TBC_MOD_RST;
    end
    else if (wr & (addr == `TBC_ADDR_MOD_HI))
    begin
      mod_q[15:8] <= wdata;
    end
    else if (wr & (addr == `TBC_ADDR_MOD_LO))
    begin
      mod_q[7:0] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Timer status and control
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tsc_q <= `TBC_TSC_RST;
      tof_armed_q <= 1'b0;
    end
    else
    begin
      if (wr & hit_tsc)
        tsc_q[6:0] <= wdata[6:0] & `TBC_TSC_WMASK;
      // Overflow in the clearing cycle keeps the flag set
      tsc_q[`TBC_B_TOF] <= ovf |
        (tsc_q[`TBC_B_TOF] & ~(wr & hit_tsc & tof_armed_q & ~wdata[`TBC_B_TOF]));
      if (wr & hit_tsc)
        tof_armed_q <= 1'b0;
      else if (rd & hit_tsc & tsc_q[`TBC_B_TOF])
        tof_armed_q <= 1'b1;
    end
  end

  assign ovf_irq = tsc_q[`TBC_B_TOF] & tsc_q[`TBC_B_TOIE]; // RULE_09

  // ----------------------------------------------------------------
  // Pair linking
  // ----------------------------------------------------------------
  assign link[0] = ctrl_q[0][`TBC_B_MSB]; // RULE_10
  assign link[1] = ctrl_q[2][`TBC_B_MSB]; // RULE_13

  always @(posedge clk or posedge rst)
  begin : pair_blk
    integer p;
    if (rst)
    begin
      link_q <= 2'h0;
      sel_q <= 2'h0;
      last_q <= 2'h0;
    end
    else
    begin
      link_q <= link;
      for (p = 0; p < 2; p = p + 1)
      begin
        if (~link[p] | ~link_q[p])
        begin
          // A fresh link always starts on the lead channel
          sel_q[p] <= 1'b0; // RULE_11 RULE_14
          last_q[p] <= 1'b0;
        end
        else
        begin
          if (wr & (hh[2*p+1] | hl[2*p+1]))
            last_q[p] <= 1'b1;
          else if (wr & (hh[2*p] | hl[2*p]))
            last_q[p] <= 1'b0;
          if (ovf)
            sel_q[p] <= last_q[p]; // RULE_11 RULE_14
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_ch
      wire [15:0] cmp_val;
      wire off;

      assign hc[i] = (addr == CTRL_ADDRS[8*i +: 8]);
      assign hh[i] = (addr == HI_ADDRS[8*i +: 8]);
      assign hl[i] = (addr == LO_ADDRS[8*i +: 8]);

      if (i % 2 == 0)
      begin : g_lead
        // Writes land straight in the compared value; no shadow stage
        assign cmp_val = (link[i/2] & sel_q[i/2]) ? val_q[i+1] : val_q[i]; // RULE_06
        assign off = 1'b0;
      end
      else
      begin : g_part
        assign cmp_val = val_q[i];
        assign off = link[i/2]; // RULE_12 RULE_15
      end

      tbc_chan u_chan (
        .clk(clk),
        .rst(rst),
        .cnt_upd(cnt_upd_q),
        .ovf(ovf),
        .cnt(cnt_q),
        .cmp_val(cmp_val),
        .mode_a(ctrl_q[i][`TBC_B_MSA]),
        .mode_b(ctrl_q[i][`TBC_B_MSB]),
        .els(ctrl_q[i][`TBC_B_ELSB:`TBC_B_ELSA]),
        .tov(ctrl_q[i][`TBC_B_TOV]),
        .full(ctrl_q[i][`TBC_B_FULL]),
        .off(off),
        .pin_s(pin_s[i]),
        .pin_o(ch_pin_out[i]),
        .drive(drive[i]),
        .cap(cap[i]),
        .evt(evt[i])
      );

      // Released pins stay undriven so port logic can take them over
      assign ch_pin_oe_n[i] = ~drive[i]; // RULE_12 RULE_15
      assign ch_irq[i] = ctrl_q[i][`TBC_B_FLAG] & ctrl_q[i][`TBC_B_IE]; // RULE_03 RULE_05 RULE_08

      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          ctrl_q[i] <= `TBC_CTRL_RST;
          armed_q[i] <= 1'b0;
        end
        else
        begin
          if (wr & hc[i])
          begin
            if (i == 3)
              ctrl_q[i][6:0] <= wdata[6:0] & `TBC_CH3_WMASK; // RULE_18
            else
              ctrl_q[i][6:0] <= wdata[6:0] & `TBC_CTRL_WMASK; // RULE_17
          end
          // Set wins over a clear in the same cycle
          ctrl_q[i][`TBC_B_FLAG] <= evt[i] |
            (ctrl_q[i][`TBC_B_FLAG] & ~(wr & hc[i] & armed_q[i] & ~wdata[`TBC_B_FLAG])); // RULE_20
          if (wr & hc[i])
            armed_q[i] <= 1'b0;
          else if (rd & hc[i] & ctrl_q[i][`TBC_B_FLAG])
            armed_q[i] <= 1'b1;
        end
      end

      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          val_q[i] <= `TBC_VAL_RST;
        end
        else if (cap[i])
        begin
          val_q[i] <= cnt_q; // RULE_01
        end
        else if (wr & hh[i])
        begin
          val_q[i][15:8] <= wdata; // RULE_06 RULE_16
        end
        else if (wr & hl[i])
        begin
          val_q[i][7:0] <= wdata; // RULE_06
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  reg [7:0] rd_d;

  // Mux kept combinational so the clocked stage holds only non-blocking updates
  always @*
  begin : rd_mux
    integer k;
    rd_d = 8'h00;
    if (hit_tsc)
      rd_d = tsc_q & ~(8'h01 << `TBC_B_TRST);
    else if (addr == `TBC_ADDR_CNT_HI)
      rd_d = cnt_q[15:8];
    else if (addr == `TBC_ADDR_CNT_LO)
      rd_d = cnt_q[7:0];
    else if (addr == `TBC_ADDR_MOD_HI)
      rd_d = mod_q[15:8];
    else if (addr == `TBC_ADDR_MOD_LO)
      rd_d = mod_q[7:0];
    for (k = 0; k < 4; k = k + 1)
    begin
      if (hc[k])
        rd_d = ctrl_q[k];
      if (hh[k])
        rd_d = val_q[k][15:8];
      if (hl[k])
        rd_d = val_q[k][7:0];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rd_d;
    else
      rdata <= 8'h00;
  end

endmodule
